// ==== hw/pdma_pkg.sv ====
package pdma_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_RX_CUR_ADDR = 12'h100;
  localparam logic [11:0] OFS_RX_CUR_CNT = 12'h104;
  localparam logic [11:0] OFS_TX_CUR_ADDR = 12'h108;
  localparam logic [11:0] OFS_TX_CUR_CNT = 12'h10C;
  localparam logic [11:0] OFS_RX_NEXT_ADDR = 12'h110;
  localparam logic [11:0] OFS_RX_NEXT_CNT = 12'h114;
  localparam logic [11:0] OFS_TX_NEXT_ADDR = 12'h118;
  localparam logic [11:0] OFS_TX_NEXT_CNT = 12'h11C;
  localparam logic [11:0] OFS_XFER_CMD = 12'h120;
  localparam logic [11:0] OFS_XFER_STATE = 12'h124;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h130;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h134;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_RX_EN_BIT = 0;
  localparam int CMD_RX_DIS_BIT = 1;
  localparam int CMD_TX_EN_BIT = 8;
  localparam int CMD_TX_DIS_BIT = 9;
  localparam int ST_RX_EN_BIT = 0;
  localparam int ST_TX_EN_BIT = 8;
  localparam int CNT_W = 16;

  // irq status bits: rx current, rx all, tx current, tx all
  localparam int IRQ_W = 4;
  localparam int IRQ_RX_CUR = 0;
  localparam int IRQ_RX_ALL = 1;
  localparam int IRQ_TX_CUR = 2;
  localparam int IRQ_TX_ALL = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [3:0] RST_IRQ = 4'h0;

  typedef struct packed {
    logic cur_done;
    logic all_done;
  } end_flags_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] cnt;
  } buf_desc_t;

endpackage : pdma_pkg

// ==== hw/pdma_channel.sv ====
`timescale 1ns/1ns
module pdma_channel
  import pdma_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic trig,
  input wire logic cur_addr_wr,
  input wire logic cur_cnt_wr,
  input wire logic next_addr_wr,
  input wire logic next_cnt_wr,
  input wire logic [31:0] wdata,
  output pdma_pkg::buf_desc_t cur,
  output pdma_pkg::buf_desc_t nxt,
  output pdma_pkg::end_flags_t flags,
  output logic xfer
);
  import pdma_pkg::*;

  buf_desc_t cur_ff, nxt_cur;
  buf_desc_t next_ff, nxt_next;

  // trigger honoured only while enabled and count left
  assign xfer = enable && trig && (cur_ff.cnt != RST_CNT); // RULE15

  always_comb begin
    nxt_cur = cur_ff;
    nxt_next = next_ff;
    if (xfer) begin
      nxt_cur.addr = cur_ff.addr + 32'h0000_0001;
      nxt_cur.cnt = cur_ff.cnt - 16'h0001;
    end
    if (cur_ff.cnt == RST_CNT && next_ff.cnt != RST_CNT) begin
      nxt_cur = next_ff; // RULE12
      nxt_next.cnt = RST_CNT; // RULE12
    end
    if (cur_addr_wr) begin
      nxt_cur.addr = wdata;
    end
    if (cur_cnt_wr) begin
      nxt_cur.cnt = wdata[CNT_W-1:0];
    end
    if (next_addr_wr) begin
      nxt_next.addr = wdata; // RULE1 RULE3
    end
    if (next_cnt_wr) begin
      nxt_next.cnt = wdata[CNT_W-1:0]; // RULE2 RULE4
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cur_ff <= '{addr: RST_ADDR, cnt: RST_CNT};
      next_ff <= '{addr: RST_ADDR, cnt: RST_CNT};
    end else begin
      cur_ff <= nxt_cur;
      next_ff <= nxt_next;
    end
  end

  assign cur = cur_ff;
  assign nxt = next_ff;
  assign flags = '{cur_done: (cur_ff.cnt == RST_CNT),
                   all_done: (cur_ff.cnt == RST_CNT) && (next_ff.cnt == RST_CNT)}; // RULE13

endmodule : pdma_channel

// ==== hw/periph_dma_next_buffer_ctrl.sv ====
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ns
// Summary of operation
// RULE1 - 32-bit receive next address register
// RULE2 - receive next count in low 16 bits
// RULE3 - 32-bit transmit next address register
// RULE4 - transmit next count in low 16 bits
// RULE5 - command bit 0 enables receive requests
// RULE6 - command bit 1 disables receive requests
// RULE7 - command bit 8 enables transmit requests
// RULE8 - command bit 9 disables transmit requests
// RULE9 - state bit 0 shows receive enable
// RULE10 - state bit 8 shows transmit enable
// RULE11 - transmit disable wins over enable
// RULE12 - zero current count loads next buffer
// RULE13 - end flags from current and next counts
// RULE14 - count register write clears end flag
// RULE15 - exhausted chain ignores peripheral trigger
module periph_dma_next_buffer_ctrl
  import pdma_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_ready,
  input wire logic tx_ready,
  output logic rx_xfer,
  output logic tx_xfer,
  output logic [31:0] rx_addr,
  output logic [31:0] tx_addr,
  output pdma_pkg::end_flags_t rx_flags,
  output pdma_pkg::end_flags_t tx_flags,
  output logic irq
);
  import pdma_pkg::*;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic acc;
  logic wr;
  logic hit;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign pready = 1'b1;

  always_comb begin
    unique case (paddr)
      OFS_RX_CUR_ADDR, OFS_RX_CUR_CNT, OFS_TX_CUR_ADDR, OFS_TX_CUR_CNT,
      OFS_RX_NEXT_ADDR, OFS_RX_NEXT_CNT, OFS_TX_NEXT_ADDR, OFS_TX_NEXT_CNT,
      OFS_XFER_CMD, OFS_XFER_STATE, OFS_IRQ_STATUS, OFS_IRQ_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = acc && !hit;

  logic w_rx_ca, w_rx_cc, w_tx_ca, w_tx_cc;
  logic w_rx_na, w_rx_nc, w_tx_na, w_tx_nc, w_cmd, w_irqs, w_mask;
  assign w_rx_ca = wr && paddr == OFS_RX_CUR_ADDR;
  assign w_rx_cc = wr && paddr == OFS_RX_CUR_CNT;
  assign w_tx_ca = wr && paddr == OFS_TX_CUR_ADDR;
  assign w_tx_cc = wr && paddr == OFS_TX_CUR_CNT;
  assign w_rx_na = wr && paddr == OFS_RX_NEXT_ADDR;
  assign w_rx_nc = wr && paddr == OFS_RX_NEXT_CNT;
  assign w_tx_na = wr && paddr == OFS_TX_NEXT_ADDR;
  assign w_tx_nc = wr && paddr == OFS_TX_NEXT_CNT;
  assign w_cmd = wr && paddr == OFS_XFER_CMD;
  assign w_irqs = wr && paddr == OFS_IRQ_STATUS;
  assign w_mask = wr && paddr == OFS_IRQ_MASK;

  // ----------------------------------------------------------------
  // peripheral ready synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rdy_s1_ff, rdy_s2_ff;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdy_s1_ff <= 2'h0;
      rdy_s2_ff <= 2'h0;
    end else begin
      rdy_s1_ff <= {tx_ready, rx_ready};
      rdy_s2_ff <= rdy_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // transfer enables
  // ----------------------------------------------------------------
  logic rx_en_ff, tx_en_ff, nxt_rx_en, nxt_tx_en;
  always_comb begin
    nxt_rx_en = rx_en_ff;
    nxt_tx_en = tx_en_ff;
    if (w_cmd) begin
      if (pwdata[CMD_RX_DIS_BIT]) begin
        nxt_rx_en = 1'b0; // RULE6
      end else if (pwdata[CMD_RX_EN_BIT]) begin
        nxt_rx_en = 1'b1; // RULE5
      end
      if (pwdata[CMD_TX_DIS_BIT]) begin
        nxt_tx_en = 1'b0; // RULE8 RULE11
      end else if (pwdata[CMD_TX_EN_BIT]) begin
        nxt_tx_en = 1'b1; // RULE7
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_en_ff <= 1'b0;
      tx_en_ff <= 1'b0;
    end else begin
      rx_en_ff <= nxt_rx_en;
      tx_en_ff <= nxt_tx_en;
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  buf_desc_t rx_cur, rx_nxt, tx_cur, tx_nxt;
  end_flags_t rx_lvl, tx_lvl;

  pdma_channel u_rx (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .enable(rx_en_ff),
    .trig(rdy_s2_ff[0]),
    .cur_addr_wr(w_rx_ca),
    .cur_cnt_wr(w_rx_cc),
    .next_addr_wr(w_rx_na),
    .next_cnt_wr(w_rx_nc),
    .wdata(pwdata),
    .cur(rx_cur),
    .nxt(rx_nxt),
    .flags(rx_lvl),
    .xfer(rx_xfer)
  );

  pdma_channel u_tx (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .enable(tx_en_ff),
    .trig(rdy_s2_ff[1]),
    .cur_addr_wr(w_tx_ca),
    .cur_cnt_wr(w_tx_cc),
    .next_addr_wr(w_tx_na),
    .next_cnt_wr(w_tx_nc),
    .wdata(pwdata),
    .cur(tx_cur),
    .nxt(tx_nxt),
    .flags(tx_lvl),
    .xfer(tx_xfer)
  );

  assign rx_addr = rx_cur.addr;
  assign tx_addr = tx_cur.addr;

  // ----------------------------------------------------------------
  // end flags and interrupt
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] lvl_d_ff, nxt_lvl_d;
  logic [IRQ_W-1:0] sts_ff, nxt_sts, mask_ff, nxt_mask;
  logic rx_clr, tx_clr;
  assign rx_clr = w_rx_cc || w_rx_nc; // RULE14
  assign tx_clr = w_tx_cc || w_tx_nc; // RULE14
  assign nxt_lvl_d = {tx_lvl.all_done, tx_lvl.cur_done, rx_lvl.all_done, rx_lvl.cur_done};
  // rising edge of each level
  assign ev = nxt_lvl_d & ~lvl_d_ff;

  always_comb begin
    nxt_sts = sts_ff;
    nxt_mask = mask_ff;
    if (w_irqs) begin
      nxt_sts = sts_ff & ~pwdata[IRQ_W-1:0];
    end
    if (rx_clr) begin
      nxt_sts[IRQ_RX_CUR] = 1'b0; // RULE14
      nxt_sts[IRQ_RX_ALL] = 1'b0; // RULE14
    end
    if (tx_clr) begin
      nxt_sts[IRQ_TX_CUR] = 1'b0; // RULE14
      nxt_sts[IRQ_TX_ALL] = 1'b0; // RULE14
    end
    nxt_sts = nxt_sts | ev; // RULE13
    if (w_mask) begin
      nxt_mask = pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sts_ff <= RST_IRQ;
      mask_ff <= RST_IRQ;
      lvl_d_ff <= 4'hF;
    end else begin
      sts_ff <= nxt_sts;
      mask_ff <= nxt_mask;
      lvl_d_ff <= nxt_lvl_d;
    end
  end

  assign rx_flags = rx_lvl; // RULE13
  assign tx_flags = tx_lvl; // RULE13
  assign irq = |(sts_ff & mask_ff);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (acc && !pwrite) begin
      unique case (paddr)
        OFS_RX_CUR_ADDR: prdata = rx_cur.addr;
        OFS_RX_CUR_CNT: prdata = {16'h0000, rx_cur.cnt};
        OFS_TX_CUR_ADDR: prdata = tx_cur.addr;
        OFS_TX_CUR_CNT: prdata = {16'h0000, tx_cur.cnt};
        OFS_RX_NEXT_ADDR: prdata = rx_nxt.addr; // RULE1
        OFS_RX_NEXT_CNT: prdata = {16'h0000, rx_nxt.cnt}; // RULE2
        OFS_TX_NEXT_ADDR: prdata = tx_nxt.addr; // RULE3
        OFS_TX_NEXT_CNT: prdata = {16'h0000, tx_nxt.cnt}; // RULE4
        OFS_XFER_STATE: begin
          prdata[ST_RX_EN_BIT] = rx_en_ff; // RULE9
          prdata[ST_TX_EN_BIT] = tx_en_ff; // RULE10
        end
        OFS_IRQ_STATUS: prdata = {28'h0000000, sts_ff};
        OFS_IRQ_MASK: prdata = {28'h0000000, mask_ff};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_rx_dis;
    @(posedge sys_clk) disable iff (!nrst)
      (w_cmd && pwdata[CMD_RX_DIS_BIT]) |=> !rx_en_ff;
  endproperty
  a_rx_dis: assert property (p_rx_dis) else $error("rx not disabled"); // RULE6

  property p_rx_en;
    @(posedge sys_clk) disable iff (!nrst)
      (w_cmd && pwdata[CMD_RX_EN_BIT] && !pwdata[CMD_RX_DIS_BIT]) |=> rx_en_ff;
  endproperty
  a_rx_en: assert property (p_rx_en) else $error("rx not enabled"); // RULE5

  property p_tx_en;
    @(posedge sys_clk) disable iff (!nrst)
      (w_cmd && pwdata[CMD_TX_EN_BIT] && !pwdata[CMD_TX_DIS_BIT]) |=> tx_en_ff;
  endproperty
  a_tx_en: assert property (p_tx_en) else $error("tx not enabled"); // RULE7

  property p_tx_dis;
    @(posedge sys_clk) disable iff (!nrst)
      (w_cmd && pwdata[CMD_TX_DIS_BIT]) |=> !tx_en_ff;
  endproperty
  a_tx_dis: assert property (p_tx_dis) else $error("tx not disabled"); // RULE8

  property p_tx_both;
    @(posedge sys_clk) disable iff (!nrst)
      (w_cmd && pwdata[CMD_TX_DIS_BIT] && pwdata[CMD_TX_EN_BIT]) |=> !tx_en_ff;
  endproperty
  a_tx_both: assert property (p_tx_both) else $error("tx both not off"); // RULE11

  property p_hold;
    @(posedge sys_clk) disable iff (!nrst)
      !w_cmd |=> (rx_en_ff == $past(rx_en_ff)) && (tx_en_ff == $past(tx_en_ff));
  endproperty
  a_hold: assert property (p_hold) else $error("enable changed"); // RULE5

  property p_state_rd;
    @(posedge sys_clk) disable iff (!nrst)
      (acc && !pwrite && paddr == OFS_XFER_STATE) |->
        prdata[ST_RX_EN_BIT] == rx_en_ff && prdata[ST_TX_EN_BIT] == tx_en_ff;
  endproperty
  a_state_rd: assert property (p_state_rd) else $error("state read wrong"); // RULE9

  property p_no_trig;
    @(posedge sys_clk) disable iff (!nrst)
      (rx_cur.cnt == 16'h0000 || !rx_en_ff) |-> !rx_xfer;
  endproperty
  a_no_trig: assert property (p_no_trig) else $error("rx moved when stopped"); // RULE15

  property p_chain;
    @(posedge sys_clk) disable iff (!nrst)
      (rx_cur.cnt == 16'h0000 && rx_nxt.cnt != 16'h0000 && !w_rx_cc && !w_rx_nc
       && !w_rx_ca && !w_rx_na) |=> rx_cur.cnt == $past(rx_nxt.cnt) && rx_nxt.cnt == 16'h0000;
  endproperty
  a_chain: assert property (p_chain) else $error("chain not loaded"); // RULE12

  property p_clr;
    @(posedge sys_clk) disable iff (!nrst)
      (w_tx_nc && !ev[IRQ_TX_CUR]) |=> !sts_ff[IRQ_TX_CUR];
  endproperty
  a_clr: assert property (p_clr) else $error("tx flag not cleared"); // RULE14

  property p_all;
    @(posedge sys_clk) disable iff (!nrst)
      $rose(tx_flags.all_done) |=> sts_ff[IRQ_TX_ALL];
  endproperty
  a_all: assert property (p_all) else $error("tx all flag not latched"); // RULE13

  c_chain: cover property (@(posedge sys_clk) disable iff (!nrst)
    rx_cur.cnt == 16'h0000 && rx_nxt.cnt != 16'h0000);
  c_xfer: cover property (@(posedge sys_clk) disable iff (!nrst) tx_xfer ##1 tx_xfer);
  c_irq: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(irq));

endmodule : periph_dma_next_buffer_ctrl

// ==== test/pdma_periph_model.sv ====
`timescale 1ns/1ns
module pdma_periph_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic rx_go,
  input wire logic tx_go,
  input wire logic slow,
  output logic rx_ready,
  output logic tx_ready
);
  logic phase_ff;
  logic rx_ff;
  logic tx_ff;
  logic nxt_phase;
  logic nxt_rx;
  logic nxt_tx;
  // ----------------------------------------------------------------
  // ready levels, gapped every other cycle when slow
  // ----------------------------------------------------------------
  always_comb begin
    nxt_phase = ~phase_ff;
    nxt_rx = rx_go & (~slow | phase_ff);
    nxt_tx = tx_go & (~slow | phase_ff);
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= 1'b0;
      rx_ff <= 1'b0;
      tx_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
    end
  end
  assign rx_ready = rx_ff;
  assign tx_ready = tx_ff;
endmodule : pdma_periph_model

// ==== test/periph_dma_next_buffer_ctrl_test.sv ====
`timescale 1ns/1ns
module periph_dma_next_buffer_ctrl_test;
  import pdma_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_ready;
  logic tx_ready;
  logic rx_xfer;
  logic tx_xfer;
  logic irq;
  logic [31:0] rx_addr;
  logic [31:0] tx_addr;
  end_flags_t rx_flags;
  end_flags_t tx_flags;
  logic rx_go = 1'b0;
  logic tx_go = 1'b0;
  logic slow = 1'b0;
  int failures = 0;
  int compares = 0;
  int rx_n = 0;
  int tx_n = 0;
  logic [31:0] rd;
  logic er;
  logic [31:0] cmd_tab [7] = '{32'h101, 32'h000, 32'h002, 32'h200, 32'h303, 32'h101, 32'h303};
  logic [31:0] st_tab [7] = '{32'h101, 32'h101, 32'h100, 32'h000, 32'h000, 32'h101, 32'h000};

  always #25 sys_clk = ~sys_clk;

  periph_dma_next_buffer_ctrl i_periph_dma_next_buffer_ctrl (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_ready(rx_ready), .tx_ready(tx_ready), .rx_xfer(rx_xfer), .tx_xfer(tx_xfer),
    .rx_addr(rx_addr), .tx_addr(tx_addr), .rx_flags(rx_flags), .tx_flags(tx_flags), .irq(irq)
  );
  pdma_periph_model i_pdma_periph_model (
    .sys_clk(sys_clk), .nrst(nrst), .rx_go(rx_go), .tx_go(tx_go), .slow(slow),
    .rx_ready(rx_ready), .tx_ready(tx_ready)
  );

  always @(posedge sys_clk) begin
    if (rx_xfer === 1'b1) rx_n++;
    if (tx_xfer === 1'b1) tx_n++;
  end
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask : rd_chk
  task run(input logic rx, input logic tx, input int cyc);
    rx_go <= rx;
    tx_go <= tx;
    repeat (cyc) @(posedge sys_clk);
    rx_go <= 1'b0;
    tx_go <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : run
  task close_out;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  initial begin
    repeat (3000) @(posedge sys_clk);
    failures++;
    close_out();
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(OFS_RX_CUR_ADDR + 12'(4 * i), 32'h0);
    rd_chk(OFS_XFER_STATE, 32'h0);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    chk_bit(er, 1'b0);
    apb(1'b1, OFS_RX_CUR_CNT, 32'h7);
    apb(1'b1, OFS_TX_CUR_CNT, 32'h7);
    apb(1'b1, OFS_RX_NEXT_ADDR, 32'hA5C3_0F81);
    apb(1'b1, OFS_RX_NEXT_CNT, 32'hFFFF_ABCD);
    apb(1'b1, OFS_TX_NEXT_ADDR, 32'h5A3C_F07E);
    apb(1'b1, OFS_TX_NEXT_CNT, 32'h1234_8001);
    rd_chk(OFS_RX_NEXT_ADDR, 32'hA5C3_0F81);
    rd_chk(OFS_RX_NEXT_CNT, 32'h0000_ABCD);
    rd_chk(OFS_TX_NEXT_ADDR, 32'h5A3C_F07E);
    rd_chk(OFS_TX_NEXT_CNT, 32'h0000_8001);
    chk_word({28'h0, rx_flags, tx_flags}, 32'h0);
    apb(1'b1, OFS_XFER_STATE, 32'hFFFF_FFFF);
    rd_chk(OFS_XFER_STATE, 32'h0);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, OFS_XFER_CMD, cmd_tab[i]);
      rd_chk(OFS_XFER_STATE, st_tab[i]);
    end
    run(1'b1, 1'b1, 20);
    chk_word(32'(rx_n + tx_n), 32'h0);
    // rx chain of two buffers, gapped trigger
    apb(1'b1, OFS_RX_CUR_ADDR, 32'h0000_1000);
    apb(1'b1, OFS_RX_CUR_CNT, 32'h2);
    apb(1'b1, OFS_RX_NEXT_ADDR, 32'h0000_2000);
    apb(1'b1, OFS_RX_NEXT_CNT, 32'h3);
    apb(1'b1, OFS_XFER_CMD, 32'h1);
    slow <= 1'b1;
    run(1'b1, 1'b0, 40);
    chk_word(32'(rx_n), 32'h5);
    chk_word(rx_addr, 32'h0000_2003);
    rd_chk(OFS_RX_NEXT_CNT, 32'h0);
    rd_chk(OFS_RX_CUR_CNT, 32'h0);
    chk_word({30'h0, rx_flags}, 32'h3);
    rd_chk(OFS_IRQ_STATUS, 32'h3);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    @(negedge sys_clk);
    chk_bit(irq, 1'b1);
    apb(1'b1, OFS_RX_NEXT_CNT, 32'h0);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    @(negedge sys_clk);
    chk_bit(irq, 1'b0);
    // tx single buffer, prompt trigger
    apb(1'b1, OFS_TX_NEXT_CNT, 32'h0);
    apb(1'b1, OFS_TX_CUR_ADDR, 32'h0000_3000);
    apb(1'b1, OFS_TX_CUR_CNT, 32'h1);
    apb(1'b1, OFS_XFER_CMD, 32'h100);
    slow <= 1'b0;
    run(1'b0, 1'b1, 20);
    chk_word(32'(tx_n), 32'h1);
    chk_word(tx_addr, 32'h0000_3001);
    chk_word({30'h0, tx_flags}, 32'h3);
    rd_chk(OFS_IRQ_STATUS, 32'hC);
    chk_bit(irq, 1'b0);
    apb(1'b1, OFS_IRQ_STATUS, 32'h4);
    rd_chk(OFS_IRQ_STATUS, 32'h8);
    apb(1'b1, OFS_IRQ_MASK, 32'h8);
    @(negedge sys_clk);
    chk_bit(irq, 1'b1);
    apb(1'b1, OFS_IRQ_STATUS, 32'h8);
    @(negedge sys_clk);
    chk_bit(irq, 1'b0);
    apb(1'b0, 12'h200, 32'h0);
    chk_bit(er, 1'b1);
    chk_word(rd, 32'h0);
    close_out();
  end
endmodule : periph_dma_next_buffer_ctrl_test
